// ### src/can_fd_delay_comp.v
// Delay compensation, ESI, debug sequencing and init/config control.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "can_fd_tdc_defines.vh"

module can_fd_delay_comp (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [31:0] regRdData,
    input  wire        mtqTick,
    input  wire        frameStart,
    input  wire        dataPhaseStart,
    input  wire        crcDelimSample,
    input  wire        samplePoint,
    input  wire        txStart,
    input  wire [4:0]  txBufIndex,
    input  wire        errorPassive,
    input  wire        fdfResEdge,
    input  wire        txBit,
    input  wire        rxPin,
    input  wire        msgStored,
    input  wire [7:0]  msgDebugId,
    input  wire        dmaAck,
    output reg         esiBit,
    output reg         bitError,
    output reg         frameIsFd,
    output reg         dbgDmaRequest,
    output reg         initActive,
    output reg         protWriteAllow
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    reg        initReq;
    reg        cfgChange;
    reg [31:0] dataBitTiming;
    reg [6:0]  compOffset;
    reg [31:0] txFdSelect;
    reg [6:0]  compValue;
    reg [1:0]  initSync;
    reg        dataPhase;
    reg        txActive;
    reg [1:0]  dbgState;

    wire compEnable = dataBitTiming[`DBT_TDC_EN];

    function isAddr;
        input [7:0] a;
        input [7:0] ofs;
        begin
            isAddr = (a == ofs);
        end
    endfunction

    wire wrCore = regWrite && isAddr(regAddr, `OFS_CORE_CTRL);
    // Protected registers take writes only with both bits set.
    wire protOk = initActive && cfgChange;

    // A config change request outside init is dropped, and the bit
    // falls on its own once init is left, so a grant from an earlier
    // init phase can never reopen the protected registers later.
    always @(posedge clk_sys) begin
        if (rst) begin
            initReq       <= `CORE_CTRL_INIT_RESET;
            cfgChange     <= 1'b0;
            dataBitTiming <= `DBT_RESET;
            compOffset    <= 7'h00;
            txFdSelect    <= 32'h00000000;
        end else begin
            if (wrCore) begin
                initReq <= regWrData[`CCR_INIT];
                if (initActive) begin
                    cfgChange <= regWrData[`CCR_CCE];
                end
            end else if (!initActive) begin
                cfgChange <= 1'b0;
            end
            if (regWrite && protOk) begin
                if (isAddr(regAddr, `OFS_DATA_BIT_TIMING)) begin
                    dataBitTiming <= regWrData;
                end
                if (isAddr(regAddr, `OFS_DELAY_COMP)) begin
                    compOffset <= regWrData[`DCR_OFS_MSB:`DCR_OFS_LSB];
                end
                if (isAddr(regAddr, `OFS_TX_FORMAT)) begin
                    txFdSelect <= regWrData;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Init crossing
    // ------------------------------------------------------------
    // The request passes two delay stages and an output stage, so the
    // read-back lags a write by three cycles; software must poll the
    // bit before it writes a new value, or a rewrite inside the lag
    // would only show the earlier value on the bit for as many cycles as it was held.
    always @(posedge clk_sys) begin
        if (rst) begin
            initSync   <= 2'b11;
            initActive <= 1'b1;
        end else begin
            initSync   <= {initSync[0], initReq};
            initActive <= initSync[1];
        end
    end

    // The pin is a registered copy of the gate and so trails it by a
    // cycle; the write path uses the gate itself, so no write is let
    // through on the stale value.
    always @(posedge clk_sys) begin
        if (rst) begin
            protWriteAllow <= 1'b0;
        end else begin
            protWriteAllow <= protOk;
        end
    end

    // ------------------------------------------------------------
    // Frame start: ESI and format
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            esiBit    <= 1'b0;
            frameIsFd <= 1'b0;
            txActive  <= 1'b0;
        end else begin
            // A start while init is in effect is refused, so no frame
            // goes out on a half-written configuration.
            if (txStart && !initActive) begin
                // Latched once so a mid-frame state change is ignored.
                esiBit    <= errorPassive;
                frameIsFd <= txFdSelect[txBufIndex];
                txActive  <= 1'b1;
            end else if (crcDelimSample) begin
                txActive <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Loop delay measurement
    // ------------------------------------------------------------
    reg        measuring;
    reg [7:0]  measCount;
    reg        rxPrev;
    // The quantum that ends the measurement is counted as well, so the
    // result covers the whole loop from the transmit edge to the
    // receive edge. The count stops at its top value instead of
    // wrapping, so a lost receive edge still ends up saturated.
    wire [7:0] measNow  = (mtqTick && measCount != 8'hFF) ?
                          measCount + 8'h01 : measCount;
    wire [8:0] delaySum = {1'b0, measNow} + {2'b00, compOffset};
    wire [6:0] satSum = (delaySum > {2'b00, `DELAY_COMP_MAX}) ?
                        `DELAY_COMP_MAX : delaySum[6:0];
    wire       rxFall = rxPrev && !rxPin;

    always @(posedge clk_sys) begin
        if (rst) begin
            measuring <= 1'b0;
            measCount <= 8'h00;
            compValue <= 7'h00;
            rxPrev    <= 1'b1;
        end else begin
            rxPrev <= rxPin;
            if (initActive) begin
                measuring <= 1'b0;
                compValue <= 7'h00;
            end else if (fdfResEdge && compEnable && frameIsFd
                         && txActive) begin
                measuring <= 1'b1;
                measCount <= 8'h00;
            end else if (measuring && rxFall) begin
                measuring <= 1'b0;
                compValue <= satSum;
            end else if (measuring && mtqTick && measCount != 8'hFF) begin
                measCount <= measCount + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Data phase bit check
    // ------------------------------------------------------------
    // The secondary point is counted from the regular sample point of
    // the bit before; it can lie at most 127 quanta behind it, which
    // the saturation of the compensation value already enforces.
    reg  [6:0]  sspCount;
    reg  [127:0] txDelay;
    reg         pendErr;
    wire        sspHit = mtqTick && (sspCount == compValue);
    wire        useComp = dataPhase && compEnable;

    always @(posedge clk_sys) begin
        if (rst) begin
            dataPhase <= 1'b0;
        end else if (frameStart || crcDelimSample) begin
            dataPhase <= 1'b0;
        end else if (dataPhaseStart && txActive && frameIsFd) begin
            dataPhase <= 1'b1;
        end
    end

    // Transmitted bits are kept per quantum so the bit that left
    // the pin one loop delay earlier is compared, not the current.
    always @(posedge clk_sys) begin
        if (rst) begin
            txDelay <= {128{1'b1}};
        end else if (mtqTick) begin
            txDelay <= {txDelay[126:0], txBit};
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            sspCount <= 7'h00;
            pendErr  <= 1'b0;
            bitError <= 1'b0;
        end else begin
            bitError <= 1'b0;
            if (!useComp) begin
                sspCount <= 7'h00;
                pendErr  <= 1'b0;
                if (samplePoint && dataPhase && txBit != rxPin) begin
                    bitError <= 1'b1;
                end
            end else begin
                if (samplePoint) begin
                    sspCount <= 7'h00;
                end else if (mtqTick && sspCount != `DELAY_COMP_MAX) begin
                    sspCount <= sspCount + 7'h01;
                end
                if (sspHit && txDelay[compValue] != rxPin) begin
                    pendErr <= 1'b1;
                end
                if (samplePoint && pendErr) begin
                    bitError <= 1'b1;
                    pendErr  <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Debug message sequencing
    // ------------------------------------------------------------
    // A wrong message restarts the sequence. A message A seen out of
    // place is taken as the first of a new sequence, so a sender that
    // repeats A after a loss is not made to send it a third time.
    localparam DBG_WAIT_A = 4'b0001;
    localparam DBG_WAIT_B = 4'b0010;
    localparam DBG_WAIT_C = 4'b0100;
    localparam DBG_DONE   = 4'b1000;
    reg [3:0] dbgSeq;
    reg [3:0] next_dbgSeq;

    always @* begin
        next_dbgSeq = dbgSeq;
        case (dbgSeq)
            DBG_WAIT_A: begin
                if (msgStored && msgDebugId == `DBG_ID_A) begin
                    next_dbgSeq = DBG_WAIT_B;
                end
            end
            DBG_WAIT_B: begin
                if (msgStored) begin
                    if (msgDebugId == `DBG_ID_B) begin
                        next_dbgSeq = DBG_WAIT_C;
                    end else if (msgDebugId == `DBG_ID_A) begin
                        next_dbgSeq = DBG_WAIT_B;
                    end else begin
                        next_dbgSeq = DBG_WAIT_A;
                    end
                end
            end
            DBG_WAIT_C: begin
                if (msgStored) begin
                    if (msgDebugId == `DBG_ID_C) begin
                        next_dbgSeq = DBG_DONE;
                    end else if (msgDebugId == `DBG_ID_A) begin
                        next_dbgSeq = DBG_WAIT_B;
                    end else begin
                        next_dbgSeq = DBG_WAIT_A;
                    end
                end
            end
            DBG_DONE: begin
                if (dmaAck) begin
                    next_dbgSeq = DBG_WAIT_A;
                end
            end
            default: next_dbgSeq = DBG_WAIT_A;
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst || initActive) begin
            dbgSeq        <= DBG_WAIT_A;
            dbgDmaRequest <= 1'b0;
        end else begin
            dbgSeq        <= next_dbgSeq;
            dbgDmaRequest <= (next_dbgSeq == DBG_DONE);
        end
    end

    always @* begin
        case (dbgSeq)
            DBG_WAIT_B: dbgState = 2'h1;
            DBG_WAIT_C: dbgState = 2'h2;
            DBG_DONE:   dbgState = 2'h3;
            default:    dbgState = 2'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Unmapped offsets read as zero, and the data stand for a single
    // cycle, so a stale value is never mistaken for a fresh answer.
    always @(posedge clk_sys) begin
        if (rst) begin
            regRdData <= 32'h00000000;
        end else if (regRead) begin
            case (regAddr)
                `OFS_CORE_CTRL:
                    regRdData <= {30'h0, cfgChange, initActive};
                `OFS_DATA_BIT_TIMING:
                    regRdData <= dataBitTiming;
                `OFS_DELAY_COMP:
                    regRdData <= {17'h0, compOffset, 8'h00};
                `OFS_PROTO_STATUS:
                    regRdData <= {9'h0, compValue, 10'h0,
                                  errorPassive, 5'h00};
                `OFS_TX_FORMAT:
                    regRdData <= txFdSelect;
                `OFS_DEBUG_STATUS:
                    regRdData <= {29'h0, dbgDmaRequest, dbgState};
                default:
                    regRdData <= 32'h00000000;
            endcase
        end else begin
            regRdData <= 32'h00000000;
        end
    end

endmodule

// ### src/can_fd_tdc_defines.vh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef CAN_FD_TDC_DEFINES_VH
`define CAN_FD_TDC_DEFINES_VH

`define CLK_PERIOD_NS        40
`define SYNC_DELAY_NS        80
`define SYNC_CYCLES          ((`SYNC_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define OFS_CORE_CTRL        8'h00
`define OFS_DATA_BIT_TIMING  8'h04
`define OFS_DELAY_COMP       8'h08
`define OFS_PROTO_STATUS     8'h0C
`define OFS_TX_FORMAT        8'h10
`define OFS_DEBUG_STATUS     8'h14

`define CCR_INIT             0
`define CCR_CCE              1
`define DBT_TDC_EN           23
`define DCR_OFS_MSB          14
`define DCR_OFS_LSB          8
`define PSR_EP               5
`define PSR_VAL_LSB          16

`define CORE_CTRL_RESET      2'h1
`define CORE_CTRL_INIT_RESET 1'b1
`define DBT_RESET            32'h00000A33
`define DELAY_COMP_MAX       7'h7F
`define DBG_ID_A             8'h7D
`define DBG_ID_B             8'hBE
`define DBG_ID_C             8'hFF

`endif

// ### tb/can_transceiver_model.sv
// Transceiver loop model: the receive pin follows the transmit pin late.
`timescale 1ns/10ps
module can_transceiver_model #(
    parameter int DELAY = 5
) (
    input  wire clk_sys,
    input  wire txBit,
    input  wire flip,
    output wire rxPin
);
    // The bus idles recessive, so the delay line starts high.
    logic [15:0] line = 16'hFFFF;
    always @(posedge clk_sys) begin
        line <= {line[14:0], txBit};
    end
    // Flip lets the bench corrupt the loop to provoke bit errors.
    assign rxPin = line[DELAY-1] ^ flip;
endmodule

// ### tb/can_fd_delay_comp_chk.sv
// Port checker for the delay compensation block.
`timescale 1ns/10ps
`include "can_fd_tdc_defines.vh"
module can_fd_delay_comp_chk (
    input wire        clk_sys,
    input wire        rst,
    input wire [7:0]  regAddr,
    input wire [31:0] regWrData,
    input wire        regWrite,
    input wire        txStart,
    input wire        errorPassive,
    input wire        samplePoint,
    input wire        msgStored,
    input wire [7:0]  msgDebugId,
    input wire        dmaAck,
    input wire        esiBit,
    input wire        bitError,
    input wire        dbgDmaRequest,
    input wire        initActive,
    input wire        protWriteAllow
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire ctrlWr = regWrite && regAddr == `OFS_CORE_CTRL;
    // ---------------------------------------------------------------
    // Sequences
    // ---------------------------------------------------------------
    sequence leaveInit;
        ctrlWr && !regWrData[`CCR_INIT] && initActive;
    endsequence
    sequence lagThenDrop;
        initActive [*3] ##1 !initActive;
    endsequence
    esi_follow_a:
        assert property (txStart && !initActive |=>
            esiBit == $past(errorPassive)) else $error("esi wrong");
    init_lag_a:
        assert property (leaveInit |=> lagThenDrop)
            else $error("init read-back lag wrong");
    cce_ignored_a:
        assert property (ctrlWr && regWrData[`CCR_CCE] && !initActive
            |=> !protWriteAllow [*2]) else $error("cce taken");
    cce_taken_a:
        assert property (ctrlWr && regWrData[1:0] == 2'b11 && initActive
            |=> ##[0:1] protWriteAllow) else $error("cce lost");
    prot_needs_init_a:
        assert property (protWriteAllow |-> initActive)
            else $error("protected write open outside init");
    err_at_sample_a:
        assert property (bitError |-> $past(samplePoint))
            else $error("bit error off sample point");
    err_pulse_a:
        assert property (bitError |=> !bitError)
            else $error("bit error longer than a cycle");
    dma_cause_a:
        assert property ($rose(dbgDmaRequest) |-> $past(msgStored)
            && $past(msgDebugId) == `DBG_ID_C)
            else $error("dma request without message c");
    dma_hold_a:
        assert property (dbgDmaRequest && !dmaAck |=> dbgDmaRequest)
            else $error("dma request dropped early");
endmodule
bind can_fd_delay_comp can_fd_delay_comp_chk can_fd_delay_comp_chk_i (
    .clk_sys, .rst, .regAddr, .regWrData, .regWrite, .txStart,
    .errorPassive, .samplePoint, .msgStored, .msgDebugId, .dmaAck,
    .esiBit, .bitError, .dbgDmaRequest, .initActive, .protWriteAllow
);

// ### tb/tb_can_fd_delay_comp.sv
// Self-checking bench for the delay compensation block.
`timescale 1ns/10ps
`include "can_fd_tdc_defines.vh"
module tb_can_fd_delay_comp;
    localparam int DLY = 6;
    logic        clk_sys, rst, regWrite, regRead, mtqTick, frameStart;
    logic        dataPhaseStart, crcDelimSample, samplePoint, txStart;
    logic        errorPassive, fdfResEdge, txBit, msgStored, dmaAck;
    logic        flip, esiBit, bitError, frameIsFd, dbgDmaRequest;
    logic        initActive, protWriteAllow, rxPin, expReq;
    logic [7:0]  regAddr, msgDebugId;
    logic [31:0] regWrData, regRdData, rv, fmt;
    logic [4:0]  txBufIndex;
    logic [7:0]  ids [$];
    logic [7:0]  seqId [3] = '{`DBG_ID_A, `DBG_ID_B, `DBG_ID_C};
    int          n_mismatch, check_count, st, ofs;
    can_fd_delay_comp can_fd_delay_comp_i (
        .clk_sys, .rst, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .mtqTick, .frameStart, .dataPhaseStart,
        .crcDelimSample, .samplePoint, .txStart, .txBufIndex,
        .errorPassive, .fdfResEdge, .txBit, .rxPin, .msgStored,
        .msgDebugId, .dmaAck, .esiBit, .bitError, .frameIsFd,
        .dbgDmaRequest, .initActive, .protWriteAllow
    );
    can_transceiver_model #(.DELAY(DLY)) can_transceiver_model_i (
        .clk_sys, .txBit, .flip, .rxPin
    );
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h, expected %h",
                     $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        @(posedge clk_sys);
    endtask
    task rd(input logic [7:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 rv = regRdData;
        @(posedge clk_sys);
    endtask
    // The read-back lags the write, so wait before trusting it.
    task setInit(input logic [31:0] v);
        wr(`OFS_CORE_CTRL, v);
        tick(3);
        rd(`OFS_CORE_CTRL);
        check(rv[`CCR_INIT], v[0]);
    endtask
    // Runs one transmitted FD frame; en says whether compensation is on.
    task tdc(input logic ep, input logic err, input logic en);
        logic [4:0] b;
        int         e;
        b = 5'($urandom);
        // Step to the next buffer set up for FD, so the frame has a
        // data phase at all.
        repeat (31) begin
            if (!fmt[b])
                b = b + 5'h01;
        end
        e = !en ? 0 : (DLY + ofs > 127) ? 127 : DLY + ofs;
        errorPassive <= ep;
        txBufIndex <= b;
        txStart <= 1'b1;
        @(posedge clk_sys);
        txStart <= 1'b0;
        frameStart <= 1'b1;
        #1 check(esiBit, ep);
        check(frameIsFd, fmt[b]);
        @(posedge clk_sys);
        frameStart <= 1'b0;
        fdfResEdge <= 1'b1;
        txBit <= 1'b0;
        @(posedge clk_sys);
        fdfResEdge <= 1'b0;
        tick(DLY + 2);
        dataPhaseStart <= 1'b1;
        @(posedge clk_sys);
        dataPhaseStart <= 1'b0;
        flip <= err;
        // Leave room for the secondary point to pass before the sample.
        tick(e + 4);
        samplePoint <= 1'b1;
        @(posedge clk_sys);
        samplePoint <= 1'b0;
        #1 check(bitError, err);
        @(posedge clk_sys);
        flip <= 1'b0;
        crcDelimSample <= 1'b1;
        @(posedge clk_sys);
        crcDelimSample <= 1'b0;
        flip <= 1'b1;
        tick(8);
        samplePoint <= 1'b1;
        @(posedge clk_sys);
        samplePoint <= 1'b0;
        flip <= 1'b0;
        txBit <= 1'b1;
        #1 check(bitError, 1'b0);
        @(posedge clk_sys);
        rd(`OFS_PROTO_STATUS);
        check(rv[22:16], e);
        check(rv[`PSR_EP], ep);
    endtask
    task dbg(input logic [7:0] id);
        int i;
        msgDebugId <= id;
        msgStored <= 1'b1;
        @(posedge clk_sys);
        msgStored <= 1'b0;
        if (id == seqId[st])
            st++;
        else
            st = (id == seqId[0]) ? 1 : 0;
        if (st == 3) begin
            st = 0;
            expReq = 1'b1;
        end
        // Look after the edge, once the registered request has settled.
        #1;
        i = 0;
        while (dbgDmaRequest !== expReq && i < 4) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        if (i == 4) begin
            n_mismatch++;
            results();
        end
        check(dbgDmaRequest, expReq);
        if (expReq) begin
            dmaAck <= 1'b1;
            @(posedge clk_sys);
            dmaAck <= 1'b0;
            expReq = 1'b0;
            @(posedge clk_sys);
            check(dbgDmaRequest, 1'b0);
        end
        @(posedge clk_sys);
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {regWrite, regRead, frameStart, dataPhaseStart, crcDelimSample,
         samplePoint, txStart, errorPassive, fdfResEdge, msgStored,
         dmaAck, flip, expReq} = '0;
        {txBit, mtqTick, rst} = 3'h7;
        {regAddr, msgDebugId, txBufIndex, regWrData} = '0;
        void'($urandom(32));
        tick(16);
        rst <= 1'b0;
        tick(2);
        rd(`OFS_CORE_CTRL);
        check(rv, {30'h0, `CORE_CTRL_RESET});
        rd(`OFS_DATA_BIT_TIMING);
        check(rv, `DBT_RESET);
        rd(8'h40);
        check(rv, 32'h0);
        $display("test reset values done");
        wr(`OFS_CORE_CTRL, 32'h3);
        #1 check(protWriteAllow, 1'b1);
        fmt = $urandom | 32'h00000001;
        ofs = $urandom % 30 + 1;
        wr(`OFS_DATA_BIT_TIMING, `DBT_RESET | 32'h00800000);
        wr(`OFS_TX_FORMAT, fmt);
        wr(`OFS_DELAY_COMP, 32'(ofs) << 8);
        setInit(32'h0);
        wr(`OFS_CORE_CTRL, 32'h2);
        rd(`OFS_CORE_CTRL);
        check(rv, 32'h0);
        wr(`OFS_TX_FORMAT, ~fmt);
        rd(`OFS_TX_FORMAT);
        check(rv, fmt);
        $display("test config access done");
        tdc(1'b0, 1'b1, 1'b1);
        tdc(1'b1, 1'b0, 1'b1);
        setInit(32'h1);
        rd(`OFS_PROTO_STATUS);
        check(rv[22:16], 7'h0);
        ofs = 124;
        wr(`OFS_CORE_CTRL, 32'h3);
        wr(`OFS_DELAY_COMP, 32'(ofs) << 8);
        setInit(32'h0);
        tdc(1'b1, 1'b1, 1'b1);
        setInit(32'h1);
        wr(`OFS_CORE_CTRL, 32'h3);
        wr(`OFS_DATA_BIT_TIMING, `DBT_RESET);
        setInit(32'h0);
        tdc(1'b0, 1'b1, 1'b0);
        $display("test delay compensation done");
        // Ids with second-ID bits 00 are never debug messages.
        ids = '{`DBG_ID_A, `DBG_ID_B, `DBG_ID_C, `DBG_ID_A, `DBG_ID_C,
                8'($urandom) & 8'h3F, `DBG_ID_A, `DBG_ID_B, 8'h15,
                `DBG_ID_C, `DBG_ID_B, `DBG_ID_A, `DBG_ID_A, `DBG_ID_B,
                `DBG_ID_C};
        foreach (ids[i])
            dbg(ids[i]);
        $display("test debug sequence done");
        results();
    end
endmodule
